/* verilog/clock_recovery_and_data_slicer.sv */
// Symbol clock recovery, lock detection and data slicing for the baseband.
// Assumes filter samples, the recovery slicer level and framer flags on mclk.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module clock_recovery_and_data_slicer import cdr_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sampleStb,
  input wire logic signed [7:0] filterVal,
  input wire logic recoveryRef,
  input wire logic configSel,
  input wire logic frameGap,
  input wire logic endOfMessage,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic chipStreamOut,
  output logic chipStreamStrobe,
  output logic symSyncLock,
  output logic chipClock
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [3:0] runinChipsA;
  logic [3:0] runinChipsB;
  logic rateEnA;
  logic rateEnB;
  logic [7:0] edgeLossWindow;
  logic [3:0] chipTol;
  logic [3:0] bitTol;
  logic [7:0] posThr;
  logic [7:0] negThr;
  logic [7:0] slicerCfg;
  logic [7:0] zeroBand;
  coding_t coding;
  logic invert;

  cdr_state_t state;
  cdr_state_t next_state;
  logic refPrev;
  logic refEdge;
  logic [5:0] widthCnt;
  logic [7:0] edgeAge;
  logic [3:0] validChips;
  logic [5:0] hist [HIST_DEPTH];
  logic [7:0] sum4;
  logic chipOk;
  logic bitOk;
  logic [3:0] runinChips;
  logic rateEn;
  logic signed [8:0] rateDev;
  logic rateBlocked;
  logic ageExpired;
  logic lockStart;
  logic [7:0] phase;
  logic [7:0] period;
  logic [7:0] halfPeriod;
  logic signed [9:0] phaseErr;
  logic signed [9:0] adjPhase;
  logic [7:0] next_phase;
  logic [7:0] next_period;
  logic chipTick;
  logic chipMode;
  logic lastChip;
  logic slicedChip;
  sym_t sym;

  chip_link_if link ();

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic inWindow(input logic [5:0] width, input logic [5:0] nominal,
                                    input logic [3:0] tol);
    logic [5:0] diff;
    diff = (width > nominal) ? width - nominal : nominal - width;
    inWindow = (diff <= {2'b00, tol});
  endfunction

  function automatic logic isChipMode(input logic [7:0] cfg);
    isChipMode = (cfg == SLC_CHIP_EOM_CV) || (cfg == SLC_CHIP_EOM_LEN) ||
                 (cfg == SLC_CHIP_TRANSP);
  endfunction

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      runinChipsA <= RUNIN_CHIPS_RST;
      runinChipsB <= RUNIN_CHIPS_RST;
      rateEnA <= 1'b0;
      rateEnB <= 1'b0;
      edgeLossWindow <= EDGE_LOSS_RST;
      chipTol <= CHIP_TOL_RST;
      bitTol <= BIT_TOL_RST;
      posThr <= POS_THR_RST;
      negThr <= NEG_THR_RST;
      slicerCfg <= SLICER_CFG_RST;
      zeroBand <= ZERO_BAND_RST;
      coding <= CODE_MANCH;
      invert <= 1'b0;
    end else if (regWr) begin
      if (regAddr == ADDR_RUNIN) begin
        runinChipsA <= regWdata[RUNIN_A_LSB +: 4];
        rateEnA <= regWdata[RATE_EN_A_BIT];
        runinChipsB <= regWdata[RUNIN_B_LSB +: 4];
        rateEnB <= regWdata[RATE_EN_B_BIT];
      end else if (regAddr == ADDR_EDGE_LOSS) begin
        edgeLossWindow <= regWdata[7:0];
      end else if (regAddr == ADDR_TOL) begin
        chipTol <= regWdata[3:0];
        bitTol <= regWdata[BIT_TOL_LSB +: 4];
      end else if (regAddr == ADDR_RATE_THR) begin
        posThr <= regWdata[7:0];
        negThr <= regWdata[NEG_THR_LSB +: 8];
      end else if (regAddr == ADDR_SLICER) begin
        slicerCfg <= regWdata[7:0];
        zeroBand <= regWdata[ZERO_BAND_LSB +: 8];
      end else if (regAddr == ADDR_CODING) begin
        coding <= coding_t'(regWdata[1:0]);
        invert <= regWdata[INVERT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || !regRd) begin
      regRdata <= 32'h0000_0000;
    end else if (regAddr == ADDR_RUNIN) begin
      regRdata <= {19'h0_0000, rateEnB, runinChipsB, 3'h0, rateEnA, runinChipsA};
    end else if (regAddr == ADDR_EDGE_LOSS) begin
      regRdata <= {24'h00_0000, edgeLossWindow};
    end else if (regAddr == ADDR_TOL) begin
      regRdata <= {20'h0_0000, bitTol, 4'h0, chipTol};
    end else if (regAddr == ADDR_RATE_THR) begin
      regRdata <= {16'h0000, negThr, posThr};
    end else if (regAddr == ADDR_SLICER) begin
      regRdata <= {16'h0000, zeroBand, slicerCfg};
    end else if (regAddr == ADDR_CODING) begin
      regRdata <= {29'h0000_0000, invert, coding};
    end else if (regAddr == ADDR_STATUS) begin
      regRdata <= {5'h00, state, period, rateDev[7:0], 6'h00, rateBlocked, symSyncLock};
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Pulse width judgement
  // ----------------------------------------------------------------------
  always_comb begin
    runinChips = configSel ? runinChipsB : runinChipsA;
    rateEn = configSel ? rateEnB : rateEnA;
    chipMode = isChipMode(slicerCfg);
    refEdge = sampleStb && (recoveryRef != refPrev);
    chipOk = inWindow(widthCnt, CHIP_SAMPLES, chipTol);
    bitOk = inWindow(widthCnt, BIT_SAMPLES, bitTol);
    sum4 = 8'h00;
    for (int i = 0; i < HIST_DEPTH; i++) begin
      sum4 = sum4 + {2'b00, hist[i]};
    end
    // Positive deviation means the sender runs fast
    rateDev = $signed({1'b0, NOM_SUM}) - $signed({1'b0, sum4});
    // Disabled limiting accepts any rate the windows pass
    rateBlocked = rateEn && ((rateDev > $signed({posThr[7], posThr})) ||
                  (rateDev < $signed({negThr[7], negThr})));
    // Unit is one sample, a sixteenth of a bit
    ageExpired = (edgeAge > edgeLossWindow) && !frameGap;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      refPrev <= 1'b0;
      widthCnt <= 6'h00;
    end else if (sampleStb) begin
      refPrev <= recoveryRef;
      if (refEdge) begin
        widthCnt <= 6'h01;
      end else if (widthCnt != WIDTH_MAX) begin
        widthCnt <= widthCnt + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || state == ST_HUNT) begin
      edgeAge <= 8'h00;
    end else if (refEdge) begin
      edgeAge <= 8'h00;
    end else if (sampleStb && !frameGap && edgeAge != AGE_MAX) begin
      edgeAge <= edgeAge + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Preset estimator, last four chip widths
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist[i] <= CHIP_SAMPLES;
      end
    end else if (refEdge && state != ST_LOCKED && (chipOk || bitOk)) begin
      hist[0] <= chipOk ? widthCnt : {1'b0, widthCnt[5:1]};
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist[i] <= hist[i - 1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Lock state machine
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_HUNT: begin
        if (refEdge) begin
          next_state = ST_RUNIN;
        end
      end
      ST_RUNIN: begin
        if (ageExpired) begin
          next_state = ST_HUNT;
        end else if (validChips >= runinChips && !rateBlocked) begin
          next_state = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (ageExpired) begin
          next_state = ST_HUNT;
        end
      end
      default: next_state = ST_HUNT;
    endcase
    if (endOfMessage) begin
      next_state = ST_HUNT;
    end
    lockStart = (state == ST_RUNIN) && (next_state == ST_LOCKED);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_HUNT;
      symSyncLock <= 1'b0;
    end else begin
      state <= next_state;
      symSyncLock <= (next_state == ST_LOCKED);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || state != ST_RUNIN) begin
      validChips <= 4'h0;
    end else if (refEdge) begin
      if (chipOk && validChips != CHIP_CNT_MAX) begin
        validChips <= validChips + 4'h1;
      end else if (bitOk && validChips < CHIP_CNT_MAX - 4'h1) begin
        validChips <= validChips + 4'h2;
      end else if (!chipOk && !bitOk) begin
        validChips <= 4'h0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Recovery oscillator, quarter-sample phase
  // ----------------------------------------------------------------------
  always_comb begin
    halfPeriod = {1'b0, period[7:1]};
    phaseErr = (phase < halfPeriod) ? $signed({2'b00, phase}) :
               $signed({2'b00, phase}) - $signed({2'b00, period});
    adjPhase = $signed({2'b00, phase}) + PHASE_STEP;
    next_period = period;
    if (refEdge) begin
      adjPhase = adjPhase - (phaseErr >>> 1);
      next_period = 8'(period + 8'(phaseErr >>> 3));
      if (next_period < PERIOD_MIN || next_period > PERIOD_MAX) begin
        next_period = period;
      end
    end
    if (adjPhase < 0) begin
      adjPhase = 10'sh000;
    end
    chipTick = sampleStb && (adjPhase >= $signed({2'b00, period}));
    next_phase = (adjPhase >= $signed({2'b00, period})) ?
                 8'(adjPhase - $signed({2'b00, period})) : adjPhase[7:0];
  end

  // Loop frozen during a start-identifier gap
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phase <= 8'h00;
      period <= NOM_SUM;
    end else if (lockStart) begin
      phase <= 8'h00;
      period <= sum4;
    end else if (state == ST_LOCKED && sampleStb && !frameGap) begin
      phase <= next_phase;
      period <= next_period;
    end
  end

  // High for the first half of each chip, two chips per bit
  always_ff @(posedge mclk) begin
    if (sys_rst || state != ST_LOCKED) begin
      chipClock <= 1'b0;
    end else if (sampleStb && !frameGap) begin
      chipClock <= (next_phase < halfPeriod);
    end
  end

  // ----------------------------------------------------------------------
  // Slicing and output stream
  // ----------------------------------------------------------------------
  symbol_slicer slicer (
    .filterVal(filterVal),
    .zeroBand(zeroBand),
    .chipMode(chipMode),
    .sym(sym)
  );

  always_comb begin
    case (sym)
      SYM_POS: slicedChip = 1'b1;
      SYM_NEG: slicedChip = 1'b0;
      default: slicedChip = lastChip;
    endcase
  end

  assign link.chipStb = chipTick && state == ST_LOCKED && !frameGap && !chipMode;
  assign link.chipIn = slicedChip;
  assign link.restart = lockStart;
  assign link.coding = coding;
  assign link.invert = invert;

  line_decoder decoder (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .link(link.dec)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lastChip <= 1'b0;
      chipStreamOut <= 1'b0;
      chipStreamStrobe <= 1'b0;
    end else begin
      chipStreamStrobe <= 1'b0;
      if (chipMode && chipTick && state == ST_LOCKED && !frameGap) begin
        lastChip <= slicedChip;
        chipStreamOut <= slicedChip;
        chipStreamStrobe <= 1'b1;
      end else if (!chipMode && link.bitStb) begin
        chipStreamOut <= link.bitVal;
        chipStreamStrobe <= 1'b1;
      end
    end
  end

endmodule // clock_recovery_and_data_slicer

/* verilog/cdr_pkg.sv */
// Constants, types and register map of the clock recovery and data slicer.
// Assumes one clock domain and a same-clock matched filter and slicer upstream.
// Operation
// - Lock drops when no reference edge arrives within the edge-loss window.
// - Start-identifier gap freezes the recovery loop and the edge-loss counter.
// - Edge-loss window counts in sixteenths of a bit period.
// - Nominal widths are 8 samples per chip, 16 per bit, with tolerance windows.
// - Separate chip and bit tolerances widen or tighten the accepted duty cycle.
// - Without rate limiting, rates beyond plus or minus 15% still lock.
// - Lock asserts after run-in count of consecutive valid-width chips.
// - Preset estimate, proportional to chip period, initialises the recovery oscillator.
// - With rate limit on, estimate beyond either threshold blocks lock.
// - Rate-limit enable per configuration, off by default; thresholds shared.
// - Default thresholds reject nearly all packets off by 10% or more.
// - Chip mode slices to +1, -1, or 0 inside the zero band.
// - Chip -1 gives zero, +1 gives one, 0 repeats the previous chip.
// - Bit mode slices at zero only, then applies line decoding.
// - Slicer values 0x90, 0x94, 0x95 select chip mode.
// - Slicer value 0x75 selects bit mode, full sensitivity, no violations.
// - Line decoder turns chips into bits by the selected Bi-phase scheme.
// - Encoding selects Manchester, differential, space or mark; inversion bit.
// - Oscillator produces the chip clock at twice the data rate.
// - End of message drops lock and resynchronises on the next telegram.
package cdr_pkg;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_RUNIN = 8'h00;
  localparam logic [7:0] ADDR_EDGE_LOSS = 8'h04;
  localparam logic [7:0] ADDR_TOL = 8'h08;
  localparam logic [7:0] ADDR_RATE_THR = 8'h0C;
  localparam logic [7:0] ADDR_SLICER = 8'h10;
  localparam logic [7:0] ADDR_CODING = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RUNIN_A_LSB = 0;
  localparam int RATE_EN_A_BIT = 4;
  localparam int RUNIN_B_LSB = 8;
  localparam int RATE_EN_B_BIT = 12;
  localparam int BIT_TOL_LSB = 8;
  localparam int NEG_THR_LSB = 8;
  localparam int ZERO_BAND_LSB = 8;
  localparam int INVERT_BIT = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] RUNIN_CHIPS_RST = 4'h6;
  localparam logic [7:0] EDGE_LOSS_RST = 8'h30;
  localparam logic [3:0] CHIP_TOL_RST = 4'h2;
  localparam logic [3:0] BIT_TOL_RST = 4'h3;
  localparam logic [7:0] POS_THR_RST = 8'h02;
  localparam logic [7:0] NEG_THR_RST = 8'hFE;
  localparam logic [7:0] SLICER_CFG_RST = 8'h75;
  localparam logic [7:0] ZERO_BAND_RST = 8'h04;

  // ----------------------------------------------------------------------
  // Slicer configuration codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] SLC_CHIP_EOM_CV = 8'h90;
  localparam logic [7:0] SLC_CHIP_EOM_LEN = 8'h94;
  localparam logic [7:0] SLC_CHIP_TRANSP = 8'h95;
  localparam logic [7:0] SLC_BIT = 8'h75;

  // ----------------------------------------------------------------------
  // Timing figures, in samples and quarter samples
  // ----------------------------------------------------------------------
  localparam logic [5:0] CHIP_SAMPLES = 6'h08;
  localparam logic [5:0] BIT_SAMPLES = 6'h10;
  localparam logic [5:0] WIDTH_MAX = 6'h3F;
  localparam logic [7:0] AGE_MAX = 8'hFF;
  localparam int HIST_DEPTH = 4;
  localparam logic [7:0] NOM_SUM = 8'h20;
  localparam logic [7:0] PERIOD_MIN = 8'h10;
  localparam logic [7:0] PERIOD_MAX = 8'hFC;
  localparam logic signed [9:0] PHASE_STEP = 10'sh004;
  localparam logic [3:0] CHIP_CNT_MAX = 4'hF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_POS = 2'h1,
    SYM_NEG = 2'h2
  } sym_t;

  typedef enum logic [1:0] {
    CODE_MANCH = 2'h0,
    CODE_DIFF = 2'h1,
    CODE_SPACE = 2'h2,
    CODE_MARK = 2'h3
  } coding_t;

  typedef enum logic [2:0] {
    ST_HUNT = 3'h1,
    ST_RUNIN = 3'h2,
    ST_LOCKED = 3'h4
  } cdr_state_t;

endpackage

/* verilog/chip_link_if.sv */
// Chip hand-off between the recovery core and the line decoder.
// Assumes both ends run on the same clock.
interface chip_link_if;
  import cdr_pkg::*;
  logic chipStb;
  logic chipIn;
  logic restart;
  coding_t coding;
  logic invert;
  logic bitStb;
  logic bitVal;

  modport ctl (output chipStb, chipIn, restart, coding, invert, input bitStb, bitVal);
  modport dec (input chipStb, chipIn, restart, coding, invert, output bitStb, bitVal);
endinterface

/* verilog/symbol_slicer.sv */
// Ternary or binary slicer of the matched filter value.
// Assumes a signed filter value on the same clock; purely combinational.
module symbol_slicer import cdr_pkg::*; (
  input wire logic signed [7:0] filterVal,
  input wire logic [7:0] zeroBand,
  input wire logic chipMode,
  output sym_t sym
);

  logic signed [8:0] bandPos;
  logic signed [8:0] bandNeg;

  always_comb begin
    bandPos = $signed({1'b0, zeroBand});
    bandNeg = -$signed({1'b0, zeroBand});
    if (chipMode) begin
      // Zero band costs sensitivity but exposes violations
      if ($signed({filterVal[7], filterVal}) > bandPos) begin
        sym = SYM_POS;
      end else if ($signed({filterVal[7], filterVal}) < bandNeg) begin
        sym = SYM_NEG;
      end else begin
        sym = SYM_ZERO;
      end
    end else begin
      // Single threshold at zero, zero counts as positive
      sym = filterVal[7] ? SYM_NEG : SYM_POS;
    end
  end

endmodule // symbol_slicer

/* verilog/line_decoder.sv */
// Pairs chips into bits according to the selected Bi-phase code.
// Assumes chip strobes from the recovery core on the same clock.
module line_decoder import cdr_pkg::*; (
  input wire logic mclk,
  input wire logic sys_rst,
  chip_link_if.dec link
);

  logic secondHalf;
  logic firstChip;
  logic prevSecond;
  logic chipVal;
  logic next_bit;

  always_comb begin
    chipVal = link.chipIn ^ link.invert;
    case (link.coding)
      CODE_MANCH: next_bit = firstChip;
      CODE_DIFF: next_bit = (firstChip == prevSecond);
      CODE_SPACE: next_bit = (firstChip == chipVal);
      CODE_MARK: next_bit = (firstChip != chipVal);
      default: next_bit = firstChip;
    endcase
  end

  // ----------------------------------------------------------------------
  // Chip pairing
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || link.restart) begin
      secondHalf <= 1'b0;
      firstChip <= 1'b0;
      prevSecond <= 1'b0;
    end else if (link.chipStb) begin
      secondHalf <= ~secondHalf;
      if (secondHalf) begin
        prevSecond <= chipVal;
      end else begin
        firstChip <= chipVal;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link.bitStb <= 1'b0;
      link.bitVal <= 1'b0;
    end else begin
      link.bitStb <= link.chipStb && secondHalf && !link.restart;
      if (link.chipStb && secondHalf) begin
        link.bitVal <= next_bit;
      end
    end
  end

endmodule // line_decoder

/* bench/cdr_asserts.sv */
// Port checker of the recovery block.
// Assumes a bind onto the top module, one clock.
module cdr_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sampleStb,
  input wire logic frameGap,
  input wire logic endOfMessage,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic chipStreamStrobe,
  input wire logic symSyncLock,
  input wire logic chipClock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_off; !symSyncLock ##1 !chipClock; endsequence
  property p_eom; endOfMessage |=> s_off; endproperty
  a_eom: assert property (p_eom) else $error("lock after eom");
  property p_stb; chipStreamStrobe |=> !chipStreamStrobe; endproperty
  a_stb: assert property (p_stb) else $error("long strobe");
  property p_clk; chipClock |-> symSyncLock || $past(symSyncLock); endproperty
  a_clk: assert property (p_clk) else $error("clock unlocked");
  // Lock rises two cycles after the sample that completed run-in
  property p_rise; $rose(symSyncLock) |-> $past(sampleStb, 2); endproperty
  a_rise: assert property (p_rise) else $error("lock without sample");
  property p_gap; symSyncLock && frameGap && !endOfMessage |=> symSyncLock; endproperty
  a_gap: assert property (p_gap) else $error("lock lost in gap");
  property p_drop; $fell(symSyncLock) |-> $past(endOfMessage) || !$past(frameGap); endproperty
  a_drop: assert property (p_drop) else $error("drop without cause");
  // Reset forces the clock low, so skip the cycle after it
  property p_frz;
    $past(frameGap) && !$past(endOfMessage) && !$past(sys_rst) |-> $stable(chipClock);
  endproperty
  a_frz: assert property (p_frz) else $error("clock moved in gap");
  property p_rd; !$past(regRd) |-> regRdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
endmodule // cdr_asserts
bind clock_recovery_and_data_slicer cdr_asserts cdr_asserts_inst (.*);

/* bench/biphase_tx.sv */
// Far-end transmitter model: an endless run of Manchester ones.
// Assumes the bench sets chip width in samples and amplitude.
// Endless identical run: no closing bit or start identifier to arrange
module biphase_tx (
  input wire logic mclk,
  input wire logic txOn,
  input wire logic [5:0] chipLen,
  input wire logic signed [7:0] amp,
  output logic sampleStb,
  output logic signed [7:0] filterVal,
  output logic recoveryRef
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt;
  initial begin
    sampleStb = 1'b0;
    recoveryRef = 1'b0;
    cnt = 6'h00;
  end
  // Silent line holds its level, so no edges reach the loop
  assign filterVal = !txOn ? 8'sh00 : recoveryRef ? amp : -amp;
  always @(posedge mclk) begin
    sampleStb <= !sampleStb;
    if (sampleStb && txOn) begin
      cnt <= (cnt + 6'h01 == chipLen) ? 6'h00 : cnt + 6'h01;
      if (cnt + 6'h01 == chipLen) begin
        recoveryRef <= !recoveryRef;
      end
    end
  end
endmodule // biphase_tx

/* bench/tb_top.sv */
// Self-checking bench of the recovery block.
// Assumes the transmitter model feeds the sample side.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cdr_pkg::*;
  logic mclk, sys_rst, sampleStb, recoveryRef, configSel, frameGap, endOfMessage;
  logic regWr, regRd, chipStreamOut, chipStreamStrobe, symSyncLock, chipClock, txOn;
  logic signed [7:0] filterVal, amp;
  logic [7:0] regAddr, v;
  logic [31:0] regWdata, regRdata;
  logic [5:0] chipLen;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  clock_recovery_and_data_slicer clock_recovery_and_data_slicer_inst (.*);
  biphase_tx biphase_tx_inst (.*);
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk("reg", e, regRdata);
  endtask
  task lockRun(input logic [5:0] w, input logic e);
    logic seen;
    seen = 1'b0;
    chipLen <= w;
    txOn <= 1'b1;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(posedge mclk);
      seen = symSyncLock;
    end
    chk("lock", e, seen);
  endtask
  task unlock;
    @(posedge mclk);
    endOfMessage <= 1'b1;
    txOn <= 1'b0;
    @(posedge mclk);
    endOfMessage <= 1'b0;
    #1;
    chk("eom", 0, symSyncLock);
  endtask
  // Skips two strobes so a mode change settles first
  task grab;
    int k;
    for (int i = 0; i < 10; i++) begin
      k = 0;
      @(posedge mclk);
      while (chipStreamStrobe !== 1'b1 && k < 300) begin
        @(posedge mclk);
        k++;
      end
      if (i > 1) v[i-2] = chipStreamOut;
    end
  endtask
  task automatic tRegs;
    logic [7:0] a [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] e [8] = '{32'h606, 32'h30, 32'h302, 32'hFE02, 32'h475, 32'h0, 32'h120_0000,
                           32'h0};
    for (int i = 0; i < 8; i++) rd(a[i], e[i]);
  endtask
  task automatic tLock;
    logic [7:0] a [6] = '{8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] d [6] = '{16'h301, 16'h302, 16'h616, 16'h1606, 16'h1606, 16'h616};
    logic [5:0] e = 6'b101010;
    for (int i = 0; i < 6; i++) begin
      wr(a[i], {16'h0, d[i]});
      configSel <= (i == 4);
      lockRun(i == 5 ? 6'h08 : 6'h06, e[i]);
      unlock();
    end
  endtask
  task automatic tDecode;
    logic [2:0] mark = 3'b100;
    wr(ADDR_SLICER, 32'h495);
    lockRun(6'h08, 1'b1);
    grab();
    chk("chips", 8'h7F, {1'b0, v[7:1] ^ v[6:0]});
    amp <= 8'sh02;
    grab();
    chk("band", 8'h00, {1'b0, v[7:1] ^ v[6:0]});
    amp <= 8'sh40;
    wr(ADDR_SLICER, 32'h475);
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_CODING, 32'(c));
      grab();
      chk("bits", {8{mark[c-1]}}, v);
    end
    unlock();
  endtask
  task tGap;
    lockRun(6'h08, 1'b1);
    frameGap <= 1'b1;
    txOn <= 1'b0;
    repeat (300) @(posedge mclk);
    chk("gap", 1, symSyncLock);
    frameGap <= 1'b0;
    repeat (60) @(posedge mclk);
    chk("age", 1, symSyncLock);
    repeat (80) @(posedge mclk);
    chk("loss", 0, symSyncLock);
    chk("clk", 0, chipClock);
  endtask
  task conclude;
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    {configSel, frameGap, endOfMessage, regWr, regRd, txOn} = 6'h00;
    regAddr = 8'h00;
    regWdata = 32'h0;
    chipLen = 6'h08;
    amp = 8'sh40;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    tRegs();
    tLock();
    tDecode();
    tGap();
    conclude();
  end
  // Ceiling well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end
endmodule // tb_top
